// file: mnp_exec.sv
// execution of multiply by file, negate file, no-operation and pop
// Function
// RULE_01: multiply by file forms the unsigned 16-bit product of the working register and the addressed file register.
// RULE_02: the product high byte gets the upper eight bits and the product low byte the lower eight.
// RULE_03: multiply by file leaves the working register, the file register and all flags untouched.
// RULE_04: a zero product raises no zero indication and the multiply produces no overflow or carry flag.
// RULE_05: access bit 0 selects the quick access bank, access bit 1 uses the bank select register.
// RULE_06: negate file replaces the addressed register with its inverted value plus one.
// RULE_07: the negated value is written back to the very location that was read.
// RULE_08: negate updates the negative, overflow, carry, digit carry and zero flags from its result.
// RULE_09: pop discards the return stack top without touching the program counter or any flag.
// RULE_10: after a pop the return stack top shows the entry pushed just before the discarded one.
// RULE_11: no-operation, all zeros or upper nibble 1111, takes one instruction cycle and changes nothing.
// RULE_12: multiply, negate and pop take one instruction cycle, reading in the second phase and writing in the fourth.
`timescale 1ns/1ps
module mnp_exec
  import mnp_pkg::*;
#(
  parameter int unsigned STK_WIDTH = STACK_WIDTH,
  parameter int unsigned STK_DEPTH = STACK_DEPTH
) (
  input  wire logic                           clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic                           instr_valid_in,
  input  wire logic [15:0]                    instr_in,
  input  wire logic [7:0]                     working_reg_in,
  input  wire logic [3:0]                     bank_select_register_in,
  input  wire logic [7:0]                     mem_rdata_in,
  input  wire logic                           stack_push_in,
  input  wire logic [STK_WIDTH-1:0]           stack_push_data_in,
  output logic      [1:0]                     phase_out,
  output logic      [11:0]                    mem_addr_out,
  output logic                                mem_rd_out,
  output logic                                mem_wr_out,
  output logic      [7:0]                     mem_wdata_out,
  output logic      [7:0]                     product_high_byte_out,
  output logic      [7:0]                     product_low_byte_out,
  output logic                                status_wr_out,
  output logic                                negative_flag_out,
  output logic                                overflow_flag_out,
  output logic                                carry_flag_out,
  output logic                                digit_carry_flag_out,
  output logic                                zero_flag_out,
  output logic      [STK_WIDTH-1:0]           return_stack_top_out,
  output logic      [$clog2(STK_DEPTH+1)-1:0] stack_depth_out,
  output logic                                done_out,
  output logic                                unsupported_out
);

  if (STK_WIDTH < 1 || STK_DEPTH < 2) begin : g_bad_param
    $error("stack width or depth out of range");
  end

  // ----------------------------------------------------------------
  // phase counter and decode
  // ----------------------------------------------------------------
  logic [1:0]  phase_reg;
  mnp_op_e     op_reg;
  logic [7:0]  w_reg;
  logic [11:0] addr_reg;
  logic        rd_reg;
  logic        wr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  prod_hi_reg;
  logic [7:0]  prod_lo_reg;
  logic        st_wr_reg;
  logic [4:0]  flags_reg;
  logic        done_reg;
  logic        unsup_reg;

  wire         at_q1      = (phase_reg == PH_Q1);
  wire         at_q3      = (phase_reg == PH_Q3);
  wire         at_q4      = (phase_reg == PH_Q4);
  wire  [6:0]  opc        = instr_in[OPC_HI:OPC_LO];
  wire  [7:0]  file_a     = instr_in[7:0];
  wire         is_mul     = (opc == MUL_FILE_OPC);
  wire         is_neg     = (opc == NEG_FILE_OPC);
  wire         is_pop     = (instr_in == POP_WORD);
  // RULE_11 both nop forms
  wire         is_nop     = (instr_in == NOP_WORD) || (instr_in[OPC_HI:NIB_LO] == NOP_NIBBLE);
  wire         take       = at_q1 && instr_valid_in;
  // RULE_05 bank selection
  wire  [3:0]  acc_bank   = (file_a >= ACCESS_SPLIT) ? ACCESS_HI_BNK : ACCESS_LO_BNK;
  wire  [3:0]  bank_sel   = instr_in[ACC_BIT] ? bank_select_register_in : acc_bank;
  wire  [11:0] addr_next  = {bank_sel, file_a};
  wire         needs_rd   = is_mul || is_neg;
  mnp_op_e     op_next;
  assign op_next = !take  ? OP_NONE :
                   is_mul ? OP_MUL  :
                   is_neg ? OP_NEG  :
                   is_pop ? OP_POP  :
                   is_nop ? OP_NOP  : OP_NONE;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  // RULE_01 unsigned product
  wire  [15:0] product    = {BYTE_ZERO, w_reg} * {BYTE_ZERO, mem_rdata_in};
  // RULE_06 two's complement
  wire  [7:0]  neg_res    = (~mem_rdata_in) + 8'h01;
  // RULE_08 flag values
  wire  [4:0]  neg_flags  = {neg_res[7], mem_rdata_in == SIGN_ONLY, mem_rdata_in == BYTE_ZERO,
                             mem_rdata_in[3:0] == NIB_ZERO, neg_res == BYTE_ZERO};
  wire         mul_fire   = at_q3 && op_reg == OP_MUL;
  wire         neg_fire   = at_q3 && op_reg == OP_NEG;
  // RULE_09 pop strobe
  wire         pop_fire   = at_q3 && op_reg == OP_POP;

  // ----------------------------------------------------------------
  // sequencing registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg <= PH_Q1;
      op_reg    <= OP_NONE;
      w_reg     <= BYTE_ZERO;
      addr_reg  <= ADDR_ZERO;
      unsup_reg <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      unsup_reg <= take && op_next == OP_NONE;
      if (at_q1) begin
        op_reg <= op_next;
      end
      if (take && needs_rd) begin
        w_reg    <= working_reg_in;
        addr_reg <= addr_next;
      end
    end
  end

  // RULE_12 read in second phase
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_reg <= 1'b0;
    end else begin
      rd_reg <= take && needs_rd;
    end
  end

  // RULE_07 write back same location
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_reg    <= 1'b0;
      wdata_reg <= BYTE_ZERO;
    end else begin
      // RULE_03 only negate writes
      wr_reg <= neg_fire;
      if (neg_fire) begin
        wdata_reg <= neg_res;
      end
    end
  end

  // RULE_02 product byte split
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prod_hi_reg <= BYTE_ZERO;
      prod_lo_reg <= BYTE_ZERO;
    end else if (mul_fire) begin
      prod_hi_reg <= product[15:8];
      prod_lo_reg <= product[7:0];
    end
  end

  // RULE_04 only negate touches flags
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_wr_reg <= 1'b0;
      flags_reg <= 5'h00;
    end else begin
      st_wr_reg <= neg_fire;
      if (neg_fire) begin
        flags_reg <= neg_flags;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= at_q4 && op_reg != OP_NONE;
    end
  end

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  mnp_ret_stack #(
    .WIDTH (STK_WIDTH),
    .DEPTH (STK_DEPTH)
  ) u_stack (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .push_in      (stack_push_in),
    .push_data_in (stack_push_data_in),
    .pop_in       (pop_fire),
    .top_out      (return_stack_top_out),
    .depth_out    (stack_depth_out)
  );

  assign phase_out             = phase_reg;
  assign mem_addr_out          = addr_reg;
  assign mem_rd_out            = rd_reg;
  assign mem_wr_out            = wr_reg;
  assign mem_wdata_out         = wdata_reg;
  assign product_high_byte_out = prod_hi_reg;
  assign product_low_byte_out  = prod_lo_reg;
  assign status_wr_out         = st_wr_reg;
  assign {negative_flag_out, overflow_flag_out, carry_flag_out, digit_carry_flag_out, zero_flag_out} = flags_reg;
  assign done_out              = done_reg;
  assign unsupported_out       = unsup_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_read_then_write;
    mem_rd_out ##2 mem_wr_out;
  endsequence

  sequence s_read_no_write;
    mem_rd_out ##1 !mem_wr_out ##1 !mem_wr_out ##1 !mem_wr_out;
  endsequence

  a_mul_product_value: assert property (mul_fire |=> // RULE_01
    {product_high_byte_out, product_low_byte_out} == $past(w_reg) * $past(mem_rdata_in))
    else $error("product does not match operands");

  a_mul_byte_split: assert property (mul_fire |=> // RULE_02
    product_high_byte_out == $past(product[15:8]) && product_low_byte_out == $past(product[7:0]))
    else $error("product bytes swapped or stale");

  a_mul_no_side: assert property ((take && is_mul) |=> s_read_no_write) // RULE_03
    else $error("multiply wrote memory");

  a_mul_no_flags: assert property ((at_q4 && op_reg == OP_MUL) |-> !status_wr_out && $stable(flags_reg)) // RULE_04
    else $error("multiply touched flags");

  a_bank_access: assert property ((take && needs_rd) |=> // RULE_05
    mem_addr_out == ($past(instr_in[ACC_BIT]) ? {$past(bank_select_register_in), $past(file_a)}
                     : {(($past(file_a) >= ACCESS_SPLIT) ? ACCESS_HI_BNK : ACCESS_LO_BNK), $past(file_a)}))
    else $error("wrong bank in address");

  a_neg_value: assert property (neg_fire |=> mem_wr_out && mem_wdata_out == 8'(0 - $past(mem_rdata_in))) // RULE_06
    else $error("negate result wrong");

  a_neg_same_addr: assert property ((take && is_neg) |=> // RULE_07
    s_read_then_write ##0 (mem_addr_out == $past(mem_addr_out, 2)))
    else $error("negate write not at read location");

  a_neg_flags: assert property (neg_fire |=> status_wr_out && zero_flag_out == (mem_wdata_out == BYTE_ZERO) // RULE_08
    && negative_flag_out == mem_wdata_out[7] && carry_flag_out == ($past(mem_rdata_in) == BYTE_ZERO))
    else $error("negate flags wrong");

  a_pop_depth: assert property ((pop_fire && stack_depth_out != '0) |=> // RULE_09
    stack_depth_out == $past(stack_depth_out) - 1'b1 && !status_wr_out)
    else $error("pop did not drop one entry");

  a_nop_quiet: assert property ((at_q1 && op_next == OP_NOP) |=> // RULE_11
    (!mem_rd_out && !mem_wr_out && !status_wr_out && $stable(product_low_byte_out)) [*3])
    else $error("no-operation changed state");

  a_one_cycle: assert property ((take && op_next != OP_NONE) |-> ##4 done_out) // RULE_12
    else $error("instruction did not finish in four clocks");

endmodule : mnp_exec

// file: mnp_pkg.sv
// constants for the multiply, negate, no-operation and pop execution block
package mnp_pkg;

  // ----------------------------------------------------------------
  // instruction phases
  // ----------------------------------------------------------------
  localparam int unsigned Q_PHASES = 4;
  localparam logic [1:0]  PH_Q1    = 2'h0;
  localparam logic [1:0]  PH_Q2    = 2'h1;
  localparam logic [1:0]  PH_Q3    = 2'h2;
  localparam logic [1:0]  PH_Q4    = 2'h3;

  // ----------------------------------------------------------------
  // encodings and fields
  // ----------------------------------------------------------------
  localparam int unsigned OPC_HI        = 15;
  localparam int unsigned OPC_LO        = 9;
  localparam int unsigned ACC_BIT       = 8;
  localparam int unsigned NIB_LO        = 12;
  localparam logic [6:0]  MUL_FILE_OPC  = 7'h01;
  localparam logic [6:0]  NEG_FILE_OPC  = 7'h36;
  localparam logic [15:0] POP_WORD      = 16'h0006;
  localparam logic [15:0] NOP_WORD      = 16'h0000;
  localparam logic [3:0]  NOP_NIBBLE    = 4'hf;

  // ----------------------------------------------------------------
  // data memory addressing
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
  localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BNK = 4'hf;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [7:0]  SIGN_ONLY     = 8'h80;
  localparam logic [3:0]  NIB_ZERO      = 4'h0;
  localparam logic [11:0] ADDR_ZERO     = 12'h000;

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  localparam int unsigned STACK_WIDTH = 21;
  localparam int unsigned STACK_DEPTH = 31;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_MUL,
    OP_NEG,
    OP_POP,
    OP_NOP
  } mnp_op_e;

endpackage : mnp_pkg

// file: mnp_ret_stack.sv
// hardware return stack held in flip-flops
`timescale 1ns/1ps
module mnp_ret_stack
  import mnp_pkg::*;
#(
  parameter int unsigned WIDTH = STACK_WIDTH,
  parameter int unsigned DEPTH = STACK_DEPTH
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       push_in,
  input  wire logic [WIDTH-1:0]           push_data_in,
  input  wire logic                       pop_in,
  output logic      [WIDTH-1:0]           top_out,
  output logic      [$clog2(DEPTH+1)-1:0] depth_out
);

  localparam int unsigned PW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] ONE = PW'(1);
  localparam logic [PW-1:0] TWO = PW'(2);

  if (DEPTH < 2) begin : g_bad_depth
    $error("stack depth must be at least two");
  end

  logic [WIDTH-1:0] entry_reg [DEPTH];
  logic [PW-1:0]    sp_reg;
  logic [WIDTH-1:0] top_reg;
  wire              do_pop   = pop_in && (sp_reg != '0);
  wire              do_push  = push_in && !pop_in && (sp_reg < PW'(DEPTH));
  wire  [PW-1:0]    below_ix = sp_reg - TWO;
  wire  [WIDTH-1:0] below_v  = (sp_reg >= TWO) ? entry_reg[below_ix] : '0;

  // ----------------------------------------------------------------
  // entry storage
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        entry_reg[i] <= '0;
      end else if (do_push && sp_reg == PW'(i)) begin
        entry_reg[i] <= push_data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // pointer and top
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sp_reg  <= '0;
      top_reg <= '0;
    end else if (do_pop) begin
      // RULE_10 previous entry surfaces
      sp_reg  <= sp_reg - ONE;
      top_reg <= below_v;
    end else if (do_push) begin
      sp_reg  <= sp_reg + ONE;
      top_reg <= push_data_in;
    end
  end

  assign top_out   = top_reg;
  assign depth_out = sp_reg;

endmodule : mnp_ret_stack

// file: mnp_exec_test.sv
// self-checking testbench for the multiply, negate, no-operation and pop block
`timescale 1ns/1ps
module mnp_exec_test;
  import mnp_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                   clk_in, rst_n_in, instr_valid_in, stack_push_in;
  logic [15:0]            instr_in;
  logic [7:0]             working_reg_in, mem_rdata_in;
  logic [3:0]             bank_select_register_in;
  logic [STACK_WIDTH-1:0] stack_push_data_in, return_stack_top_out;
  logic [1:0]             phase_out;
  logic [11:0]            mem_addr_out;
  logic                   mem_rd_out, mem_wr_out, status_wr_out, done_out, unsupported_out;
  logic [7:0]             mem_wdata_out, product_high_byte_out, product_low_byte_out;
  logic                   negative_flag_out, overflow_flag_out, carry_flag_out;
  logic                   digit_carry_flag_out, zero_flag_out;
  logic [4:0]             stack_depth_out;
  int                     n_mismatch, num_checks;
  logic                   pend_done;
  logic [15:0]            exp_prod;
  logic [4:0]             exp_flags;
  logic [STACK_WIDTH-1:0] stk[$];

  `define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t %s", $time, m); end end

  mnp_exec mnp_exec_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .working_reg_in(working_reg_in), .bank_select_register_in(bank_select_register_in),
    .mem_rdata_in(mem_rdata_in), .stack_push_in(stack_push_in), .stack_push_data_in(stack_push_data_in),
    .phase_out(phase_out), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_wdata_out(mem_wdata_out), .product_high_byte_out(product_high_byte_out),
    .product_low_byte_out(product_low_byte_out), .status_wr_out(status_wr_out),
    .negative_flag_out(negative_flag_out), .overflow_flag_out(overflow_flag_out),
    .carry_flag_out(carry_flag_out), .digit_carry_flag_out(digit_carry_flag_out),
    .zero_flag_out(zero_flag_out), .return_stack_top_out(return_stack_top_out),
    .stack_depth_out(stack_depth_out), .done_out(done_out), .unsupported_out(unsupported_out));

  always #2.5 clk_in = ~clk_in;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic wait_q4;
    int n;
    n = 0;
    while (phase_out !== PH_Q4) begin
      @(negedge clk_in);
      n++;
      if (n > 8) begin
        n_mismatch++;
        $display("[FAIL] %0t phase stuck", $time);
        test_done();
      end
    end
  endtask : wait_q4

  task automatic check_q1;
    @(negedge clk_in);
    `CHK(done_out, pend_done, "done pulse")
    pend_done = 1'b0;
  endtask : check_q1

  task automatic exec(input logic [15:0] word, input logic [7:0] w, input logic [3:0] bank_select_register, input logic [7:0] rd);
    logic [7:0]  f;
    logic [7:0]  res;
    logic [11:0] addr;
    logic        is_mul, is_neg, is_pop, known;
    f      = word[7:0];
    is_mul = word[OPC_HI:OPC_LO] == MUL_FILE_OPC;
    is_neg = word[OPC_HI:OPC_LO] == NEG_FILE_OPC;
    is_pop = word == POP_WORD;
    known  = is_mul | is_neg | is_pop | (word == NOP_WORD) | (word[15:NIB_LO] == NOP_NIBBLE);
    addr   = word[ACC_BIT] ? {bank_select_register, f} : {(f < ACCESS_SPLIT) ? ACCESS_LO_BNK : ACCESS_HI_BNK, f};
    res    = ~rd + 8'h01;
    wait_q4();
    @(posedge clk_in);
    instr_valid_in          <= 1'b1;
    instr_in                <= word;
    working_reg_in          <= w;
    bank_select_register_in <= bank_select_register;
    check_q1();
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    @(negedge clk_in);
    `CHK(mem_rd_out, is_mul | is_neg, "read strobe")
    `CHK(unsupported_out, !known, "unsupported pulse")
    if (is_mul || is_neg) `CHK(mem_addr_out, addr, "read address")
    @(posedge clk_in);
    mem_rdata_in <= rd;
    @(negedge clk_in);
    `CHK(mem_wr_out, 1'b0, "early write")
    @(posedge clk_in);
    mem_rdata_in <= ~rd;
    if (is_mul) exp_prod = {8'h00, w} * {8'h00, rd};
    if (is_neg) exp_flags = {res[7], rd == SIGN_ONLY, rd == BYTE_ZERO, rd[3:0] == NIB_ZERO, res == BYTE_ZERO};
    if (is_pop && stk.size() > 0) void'(stk.pop_back());
    @(negedge clk_in);
    `CHK(mem_wr_out, is_neg, "write strobe")
    if (is_neg) `CHK(mem_wdata_out, res, "negated value")
    if (is_neg) `CHK(mem_addr_out, addr, "write address")
    `CHK(status_wr_out, is_neg, "status write")
    `CHK(product_high_byte_out, exp_prod[15:8], "product high")
    `CHK(product_low_byte_out, exp_prod[7:0], "product low")
    `CHK({negative_flag_out, overflow_flag_out, carry_flag_out, digit_carry_flag_out, zero_flag_out},
         exp_flags, "flags")
    `CHK(stack_depth_out, 5'(stk.size()), "stack depth")
    `CHK(return_stack_top_out, (stk.size() > 0) ? stk[$] : '0, "stack top")
    pend_done = known;
  endtask : exec

  task automatic push(input logic [STACK_WIDTH-1:0] d);
    logic was_q4;
    was_q4 = (phase_out == PH_Q4);
    @(posedge clk_in);
    stack_push_in      <= 1'b1;
    stack_push_data_in <= d;
    if (was_q4) check_q1();
    else @(negedge clk_in);
    @(posedge clk_in);
    stack_push_in      <= 1'b0;
    stack_push_data_in <= ~d;
    if (stk.size() < STACK_DEPTH) stk.push_back(d);
    @(negedge clk_in);
  endtask : push

  // valid raised in the second phase must be ignored
  task automatic stray;
    wait_q4();
    @(posedge clk_in);
    check_q1();
    @(posedge clk_in);
    instr_valid_in <= 1'b1;
    instr_in       <= {NEG_FILE_OPC, 1'b0, 8'h20};
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    @(negedge clk_in);
    `CHK(mem_rd_out, 1'b0, "valid outside first phase")
  endtask : stray

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_in = 0; rst_n_in = 0; instr_valid_in = 0; instr_in = '0; working_reg_in = '0;
    bank_select_register_in = '0; mem_rdata_in = '0; stack_push_in = 0; stack_push_data_in = '0;
    n_mismatch = 0; num_checks = 0; pend_done = 0; exp_prod = '0; exp_flags = '0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    `CHK(phase_out, PH_Q1, "phase after reset")
    `CHK({product_high_byte_out, product_low_byte_out}, 16'h0000, "product reset")
    exec({MUL_FILE_OPC, 1'b1, 8'h25}, 8'hc4, 4'h3, 8'hb5);
    exec({MUL_FILE_OPC, 1'b0, 8'h90}, 8'h00, 4'h3, 8'h77);
    exec({MUL_FILE_OPC, 1'b0, 8'h7f}, 8'hff, 4'h9, 8'hff);
    exec({NEG_FILE_OPC, 1'b1, 8'h12}, 8'h55, 4'h5, 8'h3a);
    exec({NEG_FILE_OPC, 1'b0, 8'h10}, 8'h00, 4'h5, 8'h00);
    exec({NEG_FILE_OPC, 1'b0, 8'ha0}, 8'h00, 4'h6, 8'h80);
    exec({NEG_FILE_OPC, 1'b1, 8'hff}, 8'h00, 4'hf, 8'h10);
    exec({MUL_FILE_OPC, 1'b1, 8'h00}, 8'h02, 4'h1, 8'h81);
    exec(NOP_WORD, 8'h11, 4'h2, 8'h33);
    exec(16'hf5a3, 8'h11, 4'h2, 8'h33);
    exec(16'h0005, 8'h11, 4'h2, 8'h33);
    stray();
    push(21'h014332);
    push(21'h0031a2);
    exec(POP_WORD, 8'h00, 4'h0, 8'h00);
    exec(POP_WORD, 8'h00, 4'h0, 8'h00);
    exec(POP_WORD, 8'h00, 4'h0, 8'h00);
    for (int i = 0; i < 33; i++) push(21'h000100 + 21'(i));
    exec(POP_WORD, 8'h00, 4'h0, 8'h00);
    exec(NOP_WORD, 8'h00, 4'h0, 8'h00);
    check_q1();
    // mid-run reset clears stack, product and flags
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    stk.delete();
    pend_done = 1'b0;
    exp_prod  = '0;
    exp_flags = '0;
    @(negedge clk_in);
    `CHK(phase_out, PH_Q1, "phase after second reset")
    `CHK(stack_depth_out, 5'h00, "depth after second reset")
    `CHK(return_stack_top_out, 21'h00_0000, "top after second reset")
    `CHK(zero_flag_out, 1'b0, "flags after second reset")
    exec(POP_WORD, 8'h00, 4'h0, 8'h00);
    exec({NEG_FILE_OPC, 1'b0, 8'h81}, 8'h00, 4'h0, 8'h01);
    check_q1();
    test_done();
  end

endmodule : mnp_exec_test
